// File: design/fbc_consts.vh
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH

// ==========================================================================
// Clock and flash timing.
// ==========================================================================
`define FBC_CLOCK_NS          100
`define FBC_PD_PULSE_NS       100
`define FBC_WAKE_READ_NS      400
`define FBC_WAKE_WRITE_NS     1000
`define FBC_READ_ACCESS_NS    200
`define FBC_WRITE_PULSE_NS    100
`define FBC_PD_PULSE_CYC      ((`FBC_PD_PULSE_NS + `FBC_CLOCK_NS - 1) / `FBC_CLOCK_NS)
`define FBC_WAKE_READ_CYC     ((`FBC_WAKE_READ_NS + `FBC_CLOCK_NS - 1) / `FBC_CLOCK_NS)
`define FBC_WAKE_WRITE_CYC    ((`FBC_WAKE_WRITE_NS + `FBC_CLOCK_NS - 1) / `FBC_CLOCK_NS)
`define FBC_READ_ACCESS_CYC   ((`FBC_READ_ACCESS_NS + `FBC_CLOCK_NS - 1) / `FBC_CLOCK_NS)
`define FBC_WRITE_PULSE_CYC   ((`FBC_WRITE_PULSE_NS + `FBC_CLOCK_NS - 1) / `FBC_CLOCK_NS)

// ==========================================================================
// Flash command codes.
// ==========================================================================
`define FBC_CMD_READ_ARRAY    8'hFF
`define FBC_CMD_READ_ID       8'h90
`define FBC_CMD_READ_STATUS   8'h70
`define FBC_CMD_CLEAR_STATUS  8'h50
`define FBC_CMD_ERASE_SETUP   8'h20
`define FBC_CMD_CONFIRM       8'hD0
`define FBC_CMD_PROGRAM_SETUP 8'h40
`define FBC_CMD_SUSPEND       8'hB0
`define FBC_CMD_LOCK_SETUP    8'h60
`define FBC_CMD_LOCK_BLOCK    8'h01
`define FBC_CMD_LOCK_MASTER   8'hF1

// ==========================================================================
// Register map and fields.
// ==========================================================================
`define FBC_REG_CTRL          8'h00
`define FBC_REG_ADDR          8'h04
`define FBC_REG_WDATA         8'h08
`define FBC_REG_STATUS        8'h0C
`define FBC_REG_RDATA         8'h10
`define FBC_CTRL_OP_LSB       0
`define FBC_CTRL_OP_MSB       3
`define FBC_CTRL_STAY_DOWN    8
`define FBC_STAT_BUSY         0
`define FBC_STAT_READY        1
`define FBC_STAT_DOWN         2
`define FBC_STAT_REFUSED      3
`define FBC_ADDR_RESET        21'h00_0000
`define FBC_WDATA_RESET       16'h0000
`define FBC_ADDR_W            21

// ==========================================================================
// Operation codes written to the op field.
// ==========================================================================
`define FBC_OP_NONE           4'h0
`define FBC_OP_READ           4'h1
`define FBC_OP_WRITE1         4'h2
`define FBC_OP_WRITE2         4'h3
`define FBC_OP_RESET          4'h4
`define FBC_OP_RD_STATUS      4'h5
`define FBC_OP_CLR_STATUS     4'h6
`define FBC_OP_RD_ARRAY       4'h7
`define FBC_OP_SUSPEND        4'h8
`define FBC_OP_RESUME         4'h9
`define FBC_OP_ERASE          4'hA
`define FBC_OP_PROGRAM        4'hB
`define FBC_OP_RD_ID          4'hC
`define FBC_OP_LOCK_BLOCK     4'hD
`define FBC_OP_LOCK_MASTER    4'hE
`define FBC_OP_UNLOCK_ALL     4'hF

`endif

// File: design/fbc_bus_cycle.v
`timescale 1ns/1ns
`include "fbc_consts.vh"

module fbc_bus_cycle
(
  input  wire                    clk,
  input  wire                    rst_b,
  input  wire                    clk_en,
  input  wire                    start,
  input  wire                    is_read,
  input  wire [`FBC_ADDR_W-1:0]  addr,
  input  wire [7:0]              wdata,
  input  wire [7:0]              pin_data_in,
  output reg  [`FBC_ADDR_W-1:0]  pin_addr_q,
  output reg  [7:0]              pin_data_out_q,
  output reg                     pin_data_oe_q,
  output reg                     pin_ce_n_q,
  output reg                     pin_oe_n_q,
  output reg                     pin_we_n_q,
  output reg  [7:0]              rdata_q,
  output reg                     done_q
);

  // ========================================================================
  // One flash bus cycle: select, strobe, release.
  // ========================================================================
  localparam [1:0] S_IDLE   = 2'b00;
  localparam [1:0] S_STROBE = 2'b01;
  localparam [1:0] S_HOLD   = 2'b10;
  localparam [7:0] RD_CYC   = `FBC_READ_ACCESS_CYC;
  localparam [7:0] WR_CYC   = `FBC_WRITE_PULSE_CYC;

  reg [1:0] state_q;
  reg [7:0] cnt_q;
  reg       rd_q;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q        <= S_IDLE;
      cnt_q          <= 8'h00;
      rd_q           <= 1'b0;
      pin_addr_q     <= `FBC_ADDR_RESET;
      pin_data_out_q <= 8'h00;
      pin_data_oe_q  <= 1'b0;
      pin_ce_n_q     <= 1'b1;
      pin_oe_n_q     <= 1'b1;
      pin_we_n_q     <= 1'b1;
      rdata_q        <= 8'h00;
      done_q         <= 1'b0;
    end
    else if (clk_en)
    begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (start)
          begin
            rd_q           <= is_read;
            pin_addr_q     <= addr;
            pin_data_out_q <= wdata;
            // The host never drives the data pins during a read.
            pin_data_oe_q  <= !is_read;
            pin_ce_n_q     <= 1'b0;
            // A write keeps the output enable high throughout.
            pin_oe_n_q     <= !is_read;
            pin_we_n_q     <= is_read;
            cnt_q          <= is_read ? RD_CYC : WR_CYC;
            state_q        <= S_STROBE;
          end
        end
        S_STROBE:
        begin
          if (cnt_q > 8'h01)
            cnt_q <= cnt_q - 8'h01;
          else
          begin
            if (rd_q)
              rdata_q <= pin_data_in;
            // Write enable rises while chip enable is still low, so the
            // capture edge is always write enable with data still driven.
            pin_we_n_q <= 1'b1;
            pin_oe_n_q <= 1'b1;
            state_q    <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          pin_ce_n_q    <= 1'b1;
          pin_data_oe_q <= 1'b0;
          done_q        <= 1'b1;
          state_q       <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

endmodule

// File: design/fbc_host.v
`timescale 1ns/1ns
`include "fbc_consts.vh"

module fbc_host
(
  input  wire                    CLOCK,
  input  wire                    RST_B,
  input  wire                    CLK_EN,
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [7:0]              PADDR,
  input  wire [31:0]             PWDATA,
  output reg  [31:0]             PRDATA,
  output wire                    PREADY,
  output reg                     PSLVERR,
  output wire [`FBC_ADDR_W-1:0]  FL_ADDR,
  input  wire [7:0]              FL_DATA_IN,
  output wire [7:0]              FL_DATA_OUT,
  output wire                    FL_DATA_OE,
  output wire                    FL_CHIP_EN_N,
  output wire                    FL_OUT_EN_N,
  output wire                    FL_WRITE_EN_N,
  output wire                    FL_RESET_PD_N,
  input  wire                    FL_READY_BUSY_N
);

  // ========================================================================
  // Sequencer states and timing counts.
  // ========================================================================
  localparam [2:0] Q_IDLE   = 3'b000;
  localparam [2:0] Q_PD     = 3'b001;
  localparam [2:0] Q_WAIT   = 3'b010;
  localparam [2:0] Q_FIRST  = 3'b011;
  localparam [2:0] Q_SECOND = 3'b100;
  localparam [2:0] Q_RUN    = 3'b101;
  localparam [11:0] PD_CYC  = `FBC_PD_PULSE_CYC;
  localparam [11:0] WR_WAKE = `FBC_WAKE_WRITE_CYC;
  localparam [11:0] RD_WAKE = `FBC_WAKE_READ_CYC;

  // Bit 0 first access is a read, bit 1 a second access follows, bit 2 the
  // second access is a read, bits 10:3 first byte, bits 18:11 second byte.
  function [18:0] op_plan;
    input [3:0] op;
    input [7:0] hi;
    input [7:0] lo;
    begin
      case (op)
        `FBC_OP_READ:        op_plan = {8'h00, 8'h00, 3'b001};
        `FBC_OP_WRITE1:      op_plan = {8'h00, hi, 3'b000};
        `FBC_OP_WRITE2:      op_plan = {lo, hi, 3'b010};
        `FBC_OP_RD_STATUS:   op_plan = {8'h00, `FBC_CMD_READ_STATUS, 3'b110};
        `FBC_OP_RD_ARRAY:    op_plan = {8'h00, `FBC_CMD_READ_ARRAY, 3'b000};
        `FBC_OP_RD_ID:       op_plan = {8'h00, `FBC_CMD_READ_ID, 3'b110};
        `FBC_OP_CLR_STATUS:  op_plan = {8'h00, `FBC_CMD_CLEAR_STATUS, 3'b000};
        `FBC_OP_SUSPEND:     op_plan = {8'h00, `FBC_CMD_SUSPEND, 3'b000};
        `FBC_OP_RESUME:      op_plan = {8'h00, `FBC_CMD_CONFIRM, 3'b000};
        `FBC_OP_ERASE:       op_plan = {`FBC_CMD_CONFIRM, `FBC_CMD_ERASE_SETUP, 3'b010};
        `FBC_OP_PROGRAM:     op_plan = {lo, `FBC_CMD_PROGRAM_SETUP, 3'b010};
        `FBC_OP_LOCK_BLOCK:  op_plan = {`FBC_CMD_LOCK_BLOCK, `FBC_CMD_LOCK_SETUP, 3'b010};
        `FBC_OP_LOCK_MASTER: op_plan = {`FBC_CMD_LOCK_MASTER, `FBC_CMD_LOCK_SETUP, 3'b010};
        `FBC_OP_UNLOCK_ALL:  op_plan = {`FBC_CMD_CONFIRM, `FBC_CMD_LOCK_SETUP, 3'b010};
        default:             op_plan = 19'h0_0000;
      endcase
    end
  endfunction

  reg  [2:0]              state_q;
  reg  [3:0]              op_q;
  reg                     stay_down_q;
  reg  [`FBC_ADDR_W-1:0]  addr_q;
  reg  [15:0]             wdata_q;
  reg  [7:0]              rdata_q;
  reg                     refused_q;
  reg                     rp_n_q;
  reg  [11:0]             pd_cnt_q;
  reg  [11:0]             wake_cnt_q;
  reg                     start_q;
  reg                     cyc_read_q;
  reg  [7:0]              cyc_data_q;
  wire [18:0]             plan;
  wire                    wr_access;
  wire                    rd_access;
  wire                    ctrl_wr;
  wire                    stat_wr;
  wire                    busy;
  wire                    wake_ok;
  wire [7:0]              cyc_rdata;
  wire                    cyc_done;

  assign plan      = op_plan(op_q, wdata_q[15:8], wdata_q[7:0]);
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_access = PSEL && !PENABLE && !PWRITE;
  assign ctrl_wr   = wr_access && (PADDR == `FBC_REG_CTRL);
  assign stat_wr   = wr_access && (PADDR == `FBC_REG_STATUS);
  assign busy      = (state_q != Q_IDLE);
  // Commands wait longer after wake-up than a plain first read does.
  assign wake_ok   = plan[0] ? (wake_cnt_q >= RD_WAKE) : (wake_cnt_q >= WR_WAKE);
  assign PREADY    = 1'b1;
  assign FL_RESET_PD_N = rp_n_q;

  // ========================================================================
  // Register bus: zero wait states, read data registered in the setup cycle.
  // ========================================================================
  always @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      PRDATA      <= 32'h0000_0000;
      PSLVERR     <= 1'b0;
      addr_q      <= `FBC_ADDR_RESET;
      wdata_q     <= `FBC_WDATA_RESET;
      stay_down_q <= 1'b0;
      refused_q   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (PSEL && !PENABLE)
      begin
        PSLVERR <= !((PADDR == `FBC_REG_CTRL) || (PADDR == `FBC_REG_ADDR) ||
                     (PADDR == `FBC_REG_WDATA) || (PADDR == `FBC_REG_STATUS) ||
                     (PADDR == `FBC_REG_RDATA));
        PRDATA  <= 32'h0000_0000;
        if (rd_access)
        begin
          case (PADDR)
            `FBC_REG_CTRL:   PRDATA <= {23'h00_0000, stay_down_q, 4'h0, op_q};
            `FBC_REG_ADDR:   PRDATA <= {11'h000, addr_q};
            `FBC_REG_WDATA:  PRDATA <= {16'h0000, wdata_q};
            `FBC_REG_STATUS: PRDATA <= {28'h000_0000, refused_q, !rp_n_q,
                                        FL_READY_BUSY_N, busy};
            `FBC_REG_RDATA:  PRDATA <= {24'h00_0000, rdata_q};
            default:         PRDATA <= 32'h0000_0000;
          endcase
        end
      end
      if (wr_access && (PADDR == `FBC_REG_ADDR) && !busy)
        addr_q <= PWDATA[`FBC_ADDR_W-1:0];
      if (wr_access && (PADDR == `FBC_REG_WDATA) && !busy)
        wdata_q <= PWDATA[15:0];
      if (ctrl_wr)
        stay_down_q <= PWDATA[`FBC_CTRL_STAY_DOWN];
      // A new refusal in the clearing cycle is kept.
      if (ctrl_wr && busy && (state_q != Q_PD))
        refused_q <= 1'b1;
      else if (stat_wr && PWDATA[`FBC_STAT_REFUSED])
        refused_q <= 1'b0;
    end
  end

  // ========================================================================
  // Operation sequencer.
  // ========================================================================
  always @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      state_q    <= Q_PD;
      op_q       <= `FBC_OP_NONE;
      // The flash is held in reset together with this block.
      rp_n_q     <= 1'b0;
      pd_cnt_q   <= 12'h000;
      wake_cnt_q <= 12'h000;
      start_q    <= 1'b0;
      cyc_read_q <= 1'b0;
      cyc_data_q <= 8'h00;
      rdata_q    <= 8'h00;
    end
    else if (CLK_EN)
    begin
      start_q <= 1'b0;
      if (rp_n_q && (wake_cnt_q != 12'hFFF))
        wake_cnt_q <= wake_cnt_q + 12'h001;
      if (cyc_done && cyc_read_q)
        rdata_q <= cyc_rdata;
      case (state_q)
        Q_IDLE:
        begin
          if (ctrl_wr && (PWDATA[3:0] == `FBC_OP_RESET))
          begin
            rp_n_q   <= 1'b0;
            pd_cnt_q <= 12'h000;
            state_q  <= Q_PD;
          end
          else if (ctrl_wr && (PWDATA[3:0] != `FBC_OP_NONE))
          begin
            op_q    <= PWDATA[`FBC_CTRL_OP_MSB:`FBC_CTRL_OP_LSB];
            state_q <= Q_WAIT;
          end
        end
        Q_PD:
        begin
          // The pulse is never shorter than the minimum; a held stay-down
          // bit keeps the flash in deep power-down after it.
          if (pd_cnt_q < PD_CYC)
            pd_cnt_q <= pd_cnt_q + 12'h001;
          else if (!stay_down_q)
          begin
            rp_n_q     <= 1'b1;
            wake_cnt_q <= 12'h000;
            state_q    <= Q_IDLE;
          end
        end
        Q_WAIT:
        begin
          if (wake_ok)
          begin
            start_q    <= 1'b1;
            cyc_read_q <= plan[0];
            cyc_data_q <= plan[10:3];
            state_q    <= Q_FIRST;
          end
        end
        Q_FIRST:
        begin
          if (cyc_done && plan[1])
          begin
            start_q    <= 1'b1;
            cyc_read_q <= plan[2];
            cyc_data_q <= plan[18:11];
            state_q    <= Q_SECOND;
          end
          else if (cyc_done)
            state_q <= Q_IDLE;
        end
        Q_SECOND:
        begin
          if (cyc_done)
            state_q <= Q_IDLE;
        end
        default:
          state_q <= Q_IDLE;
      endcase
    end
  end

  fbc_bus_cycle u_cycle
  (
    .clk            (CLOCK),
    .rst_b          (RST_B),
    .clk_en         (CLK_EN),
    .start          (start_q),
    .is_read        (cyc_read_q),
    .addr           (addr_q),
    .wdata          (cyc_data_q),
    .pin_data_in    (FL_DATA_IN),
    .pin_addr_q     (FL_ADDR),
    .pin_data_out_q (FL_DATA_OUT),
    .pin_data_oe_q  (FL_DATA_OE),
    .pin_ce_n_q     (FL_CHIP_EN_N),
    .pin_oe_n_q     (FL_OUT_EN_N),
    .pin_we_n_q     (FL_WRITE_EN_N),
    .rdata_q        (cyc_rdata),
    .done_q         (cyc_done)
  );

endmodule

// File: bench/fbc_host_props.sv
`timescale 1ns/1ns
module fbc_host_props
(
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic [20:0] FL_ADDR,
  input wire logic        FL_DATA_OE,
  input wire logic        FL_CHIP_EN_N,
  input wire logic        FL_OUT_EN_N,
  input wire logic        FL_WRITE_EN_N,
  input wire logic        FL_RESET_PD_N
);
  // ==========================================================================
  // Strobe shapes on the flash pins.
  // ==========================================================================
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  sequence write_pulse_s;
    !FL_CHIP_EN_N ##1 FL_WRITE_EN_N && !FL_CHIP_EN_N ##1 FL_CHIP_EN_N;
  endsequence
  sequence read_pulse_s;
    !FL_OUT_EN_N [*2] ##1 FL_OUT_EN_N && !FL_CHIP_EN_N ##1 FL_CHIP_EN_N;
  endsequence
  write_shape_a: assert property ($fell(FL_WRITE_EN_N) |-> FL_OUT_EN_N ##0 write_pulse_s)
    else $error("Write strobe out of shape.");
  read_shape_a: assert property ($fell(FL_OUT_EN_N) |-> FL_WRITE_EN_N ##0 read_pulse_s)
    else $error("Read strobe out of shape.");
  no_clash_a: assert property (!FL_OUT_EN_N |-> !FL_DATA_OE && FL_WRITE_EN_N)
    else $error("Host drives data while the flash may drive.");
  data_drive_a: assert property (FL_DATA_OE |-> !FL_CHIP_EN_N && FL_OUT_EN_N)
    else $error("Host drives data outside a write.");
  addr_hold_a: assert property (!FL_CHIP_EN_N && $past(!FL_CHIP_EN_N) |-> $stable(FL_ADDR))
    else $error("Address moved while selected.");
  pd_quiet_a: assert property (!FL_RESET_PD_N |-> FL_CHIP_EN_N && FL_WRITE_EN_N)
    else $error("Strobe active in power-down.");
  // A read launched too soon after wake would return garbage, so the select must wait.
  read_wake_a: assert property ($rose(FL_RESET_PD_N) |-> FL_CHIP_EN_N [*4])
    else $error("Select too soon after wake.");
  write_wake_a: assert property ($rose(FL_RESET_PD_N) |-> FL_WRITE_EN_N [*8])
    else $error("Write too soon after wake.");
endmodule
bind fbc_host fbc_host_props i_fbc_host_props (.CLOCK, .RST_B, .FL_ADDR, .FL_DATA_OE,
  .FL_CHIP_EN_N, .FL_OUT_EN_N, .FL_WRITE_EN_N, .FL_RESET_PD_N);

// File: bench/fbc_flash_model.sv
`timescale 1ns/1ns
module fbc_flash_model
#(
  parameter logic [7:0] FILL  = 8'hC3,
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEVC  = 8'h3C, // Arbitrary value.
  parameter int         STEPS = 60
)
(
  input  wire logic [20:0] addr,
  input  wire logic [7:0]  din,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n,
  output logic      [7:0]  dq,
  output logic             rb_n = 1'b1
);
  logic [7:0]  mem [16];
  logic [7:0]  sr = 8'h80, setup = 8'h00, last = 8'h00, cmd, dat, rd;
  logic [1:0]  mode = 2'd0;
  logic [1:0]  lock = 2'b00;
  logic        mlock = 1'b0, run = 1'b0, susp = 1'b0;
  logic [20:0] oa;
  int          left;
  // ==========================================================================
  // Read path.
  // ==========================================================================
  initial foreach (mem[i]) mem[i] = FILL ^ 8'(i);
  always_comb
    case (mode)
      2'd1: rd = (addr[1:0] == 2'd0) ? MAKER : (addr[1:0] == 2'd1) ? DEVC :
                 {7'h00, (addr[1:0] == 2'd3) ? mlock : lock[addr[16]]};
      2'd2: rd = sr;
      default: rd = mem[addr[3:0]];
    endcase
  // Released pins show the complement of the last byte, so stale data never reads as valid.
  assign dq = (!ce_n && !oe_n && we_n && rp_n) ? rd : ~last;
  always @(dq) if (!ce_n && !oe_n && rp_n) last = dq;
  // ==========================================================================
  // Command capture.
  // ==========================================================================
  always @(posedge we_n) if (!ce_n && oe_n && rp_n) take(din, addr);
  always @(posedge ce_n) if (!we_n && oe_n && rp_n) take(din, addr);
  task automatic take(input logic [7:0] d, input logic [20:0] a);
    if (setup != 8'h00)
    begin
      cmd = setup;
      dat = d;
      oa = a;
      setup = 8'h00;
      mode = 2'd2;
      if (cmd == 8'h20 && d != 8'hD0 || cmd == 8'h60 && !(d inside {8'h01, 8'hF1, 8'hD0}))
        sr[5:4] = 2'b11;
      else
      begin
        run = 1'b1;
        left = STEPS;
        rb_n = 1'b0;
        sr[7] = 1'b0;
      end
    end
    else if (run && !susp && !(d inside {8'hB0, 8'h70}))
      left = left;
    else
      case (d)
        8'hFF: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h50: if (!run) sr[5:1] = 5'h00;
        8'hB0: if (run) {susp, rb_n, sr[7], mode} = {3'b111, 2'd2};
        8'hD0: if (susp) {susp, rb_n, sr[7]} = 3'b000;
        8'h20, 8'h40, 8'h10, 8'h60: if (!run) setup = d;
        default: setup = 8'h00;
      endcase
  endtask
  // ==========================================================================
  // Internal operation timer.
  // ==========================================================================
  always
  begin
    #100;
    if (run && !susp && rp_n && --left == 0)
    begin
      {run, rb_n, sr[7]} = 3'b011;
      if (cmd == 8'h60 && dat == 8'h01)
        lock[oa[16]] = 1'b1;
      else if (cmd == 8'h60 && dat == 8'hF1)
        mlock = 1'b1;
      else if (cmd == 8'h60)
        lock = 2'b00;
      else if (lock[oa[16]])
        sr = sr | (cmd == 8'h20 ? 8'h22 : 8'h12);
      else if (cmd == 8'h20)
        foreach (mem[i]) mem[i] = 8'hFF;
      else
        mem[oa[3:0]] &= dat;
    end
  end
  always @(negedge rp_n)
  begin
    {setup, mode, sr, susp} = {8'h00, 2'd0, 8'h80, 1'b0};
    if (run)
    begin
      run = 1'b0;
      #200;
    end
    rb_n = 1'b1;
  end
endmodule

// File: bench/fbc_host_bench.sv
`timescale 1ns/1ns
`include "fbc_consts.vh"
module fbc_host_bench;
  localparam logic [7:0] FILL = 8'hC3;
  logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        en = 1'b1;
  logic [7:0]  paddr = 8'h00, b, dout, dq;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, e, doe, ce_n, oe_n, we_n, rp_n, rb_n;
  logic [20:0] fl_addr;
  int          err_count = 0, check_count = 0;
  always #50 clock = ~clock;
  fbc_host i_fbc_host (.CLOCK(clock), .RST_B(rst_b), .CLK_EN(en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FL_ADDR(fl_addr), .FL_DATA_IN(doe ? dout : dq),
    .FL_DATA_OUT(dout), .FL_DATA_OE(doe), .FL_CHIP_EN_N(ce_n), .FL_OUT_EN_N(oe_n),
    .FL_WRITE_EN_N(we_n), .FL_RESET_PD_N(rp_n), .FL_READY_BUSY_N(rb_n));
  fbc_flash_model #(.FILL(FILL)) i_fbc_flash_model (.addr(fl_addr), .din(dout), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .dq(dq), .rb_n(rb_n));
  // ==========================================================================
  // Bus and check tasks.
  // ==========================================================================
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge clock);
    chk("apb ready", 32'h0000_0001, {31'h0000_0000, pready});
    if (n == 20)
      wrap_up();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Polls one status bit; the bound keeps a stuck flag from hanging the run.
  task automatic poll(input int bit_no, input logic want);
    int n;
    for (n = 0; n < 120; n++)
    begin
      apb(1'b0, `FBC_REG_STATUS, 32'h0000_0000);
      if (q[bit_no] === want)
        break;
    end
    chk("status wait", {31'h0000_0000, want}, {31'h0000_0000, q[bit_no]});
    if (n == 120)
      wrap_up();
  endtask
  task automatic op(input logic [3:0] code, input logic [20:0] a, input logic [15:0] d);
    apb(1'b1, `FBC_REG_ADDR, {11'h000, a});
    apb(1'b1, `FBC_REG_WDATA, {16'h0000, d});
    apb(1'b1, `FBC_REG_CTRL, {28'h000_0000, code});
    poll(`FBC_STAT_BUSY, 1'b0);
    apb(1'b0, `FBC_REG_RDATA, 32'h0000_0000);
    b = q[7:0];
  endtask
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    // Address and data writes are ignored until the power-down pulse after reset ends.
    poll(`FBC_STAT_BUSY, 1'b0);
    op(`FBC_OP_READ, 21'h00_0003, 16'h0000);
    chk("array after reset", FILL ^ 8'h03, b);
    for (int i = 0; i < 4; i++)
    begin
      op(`FBC_OP_RD_ID, 21'(i), 16'h0000);
      chk("identifier", i == 0 ? 8'h5A : i == 1 ? 8'h3C : 8'h00, b);
    end
    op(`FBC_OP_PROGRAM, 21'h00_0005, 16'h000F);
    op(`FBC_OP_READ, 21'h00_0005, 16'h0000);
    chk("status while busy", 8'h00, b);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_WRITE2, 21'h00_0006, 16'h10F0);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_RD_STATUS, 21'h00_0000, 16'h0000);
    chk("status done", 8'h80, b);
    op(`FBC_OP_RD_ARRAY, 21'h00_0000, 16'h0000);
    op(`FBC_OP_READ, 21'h00_0005, 16'h0000);
    chk("program 40", (FILL ^ 8'h05) & 8'h0F, b);
    op(`FBC_OP_READ, 21'h00_0006, 16'h0000);
    chk("program 10", (FILL ^ 8'h06) & 8'hF0, b);
    op(`FBC_OP_ERASE, 21'h00_0000, 16'h0000);
    op(`FBC_OP_RD_ARRAY, 21'h00_0000, 16'h0000);
    op(`FBC_OP_READ, 21'h00_0005, 16'h0000);
    chk("status during erase", 8'h00, b);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_RD_ARRAY, 21'h00_0000, 16'h0000);
    op(`FBC_OP_READ, 21'h00_0005, 16'h0000);
    chk("erased", 8'hFF, b);
    op(`FBC_OP_PROGRAM, 21'h00_0002, 16'h0000);
    op(`FBC_OP_SUSPEND, 21'h00_0000, 16'h0000);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_RESUME, 21'h00_0000, 16'h0000);
    poll(`FBC_STAT_READY, 1'b0);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_LOCK_BLOCK, 21'h00_0000, 16'h0000);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_ERASE, 21'h00_0000, 16'h0000);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_RD_STATUS, 21'h00_0000, 16'h0000);
    chk("locked erase", 8'hA2, b);
    op(`FBC_OP_CLR_STATUS, 21'h00_0000, 16'h0000);
    op(`FBC_OP_RD_STATUS, 21'h00_0000, 16'h0000);
    chk("cleared", 8'h80, b);
    op(`FBC_OP_UNLOCK_ALL, 21'h00_0000, 16'h0000);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_LOCK_MASTER, 21'h00_0000, 16'h0000);
    poll(`FBC_STAT_READY, 1'b1);
    op(`FBC_OP_RD_ID, 21'h00_0003, 16'h0000);
    chk("master lock", 8'h01, b);
    op(`FBC_OP_PROGRAM, 21'h00_0002, 16'h0000);
    op(`FBC_OP_RESET, 21'h00_0000, 16'h0000);
    op(`FBC_OP_RD_STATUS, 21'h00_0000, 16'h0000);
    chk("status after wake", 8'h80, b);
    op(`FBC_OP_RD_ARRAY, 21'h00_0000, 16'h0000);
    op(`FBC_OP_READ, 21'h00_0007, 16'h0000);
    chk("array after wake", 8'hFF, b);
    apb(1'b1, `FBC_REG_CTRL, {28'h000_0000, `FBC_OP_WRITE2});
    apb(1'b1, `FBC_REG_CTRL, {28'h000_0000, `FBC_OP_RD_STATUS});
    poll(`FBC_STAT_BUSY, 1'b0);
    chk("refused", 32'h0000_0001, {31'h0000_0000, q[`FBC_STAT_REFUSED]});
    apb(1'b1, `FBC_REG_STATUS, 32'h0000_0008);
    apb(1'b0, `FBC_REG_STATUS, 32'h0000_0000);
    chk("refused clear", 32'h0000_0000, {31'h0000_0000, q[`FBC_STAT_REFUSED]});
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
    chk("unmapped data", 32'h0000_0000, q);
    en <= 1'b0;
    apb(1'b1, `FBC_REG_ADDR, 32'h0000_0009);
    en <= 1'b1;
    apb(1'b0, `FBC_REG_ADDR, 32'h0000_0000);
    chk("frozen address", 32'h0000_0007, q);
    wrap_up();
  end
endmodule
